// [bic_consts.vh]
`ifndef BIC_CONSTS_VH
`define BIC_CONSTS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define BIC_CTRL      8'h00
`define BIC_INSTR     8'h04
`define BIC_ICNT      8'h08
`define BIC_LINK      8'h0c
`define BIC_STAT      8'h10
`define BIC_DADDR     8'h14
`define BIC_SKEY      8'h18
`define BIC_MTOP      8'h1c
`define BIC_SUBJ      8'h20
`define BIC_XSUB      8'h24
`define BIC_NEXTR     8'h28
`define BIC_SBUS      8'h2c
`define BIC_NEXT      8'h30
`define BIC_GREG_SEL  2'h1
// ----------------------------------------
// fields
// ----------------------------------------
`define BIC_CTRL_START  0
`define BIC_CTRL_RSTAB  1
`define BIC_CTRL_LASTHW 2
`define BIC_CTRL_KEY_LO 4
`define BIC_CTRL_CODE_LO 8
`define BIC_SK_FP       4
`define BIC_MASTER_KEY  4'h0
`define BIC_MTOP_RST    32'h00010000
// ----------------------------------------
// operation codes and interruption codes
// ----------------------------------------
`define BIC_OP_LBR    8'h05
`define BIC_OP_CBR    8'h06
`define BIC_OP_MBR    8'h07
`define BIC_OP_EX     8'h44
`define BIC_OP_LBX    8'h45
`define BIC_OP_CBX    8'h46
`define BIC_OP_MBX    8'h47
`define BIC_OP_IHB    8'h86
`define BIC_PIC_NONE  4'h0
`define BIC_PIC_EXEC  4'h3
`define BIC_PIC_PROT  4'h4
`define BIC_PIC_ADDR  4'h5
`define BIC_PIC_SPEC  4'h6
`define BIC_RESP_OK   2'h0
`define BIC_RESP_ERR  2'h2
`endif

// [bic_addr_gen.v]
`timescale 1ns/100ps
`include "bic_consts.vh"
module bic_addr_gen (
  input  wire [3:0]  index_register_field,
  input  wire [3:0]  base_register_field,
  input  wire [11:0] displacement_field,
  input  wire        use_index,
  input  wire [31:0] index_val,
  input  wire [31:0] base_val,
  output wire [31:0] addr
);
  wire [31:0] x_term;
  wire [31:0] b_term;
  // ----------------------------------------
  // operand address adder
  // ----------------------------------------
  // a zero field means no component, not general register zero
  assign x_term = (use_index && index_register_field != 4'h0) ? index_val : 32'h0;
  assign b_term = (base_register_field != 4'h0) ? base_val : 32'h0;
  assign addr   = x_term + b_term + {20'h0, displacement_field};
endmodule

// [bic_cond_eval.v]
`timescale 1ns/100ps
`include "bic_consts.vh"
module bic_cond_eval (
  input  wire [7:0]  opcode,
  input  wire [3:0]  condition_mask_field,
  input  wire [1:0]  condition_code,
  input  wire        rb_zero,
  input  wire [31:0] count_result,
  input  wire [31:0] index_sum,
  input  wire [31:0] comparand,
  output reg         taken
);
  reg code_sel;
  // ----------------------------------------
  // success test
  // ----------------------------------------
  always @* begin
    code_sel = condition_mask_field[2'd3 - condition_code];
    case (opcode)
      `BIC_OP_LBX:  taken = 1'b1;
      `BIC_OP_LBR:  taken = ~rb_zero;
      `BIC_OP_MBX:  taken = code_sel;
      `BIC_OP_MBR:  taken = code_sel & ~rb_zero;
      `BIC_OP_CBX:  taken = (count_result != 32'h0);
      `BIC_OP_CBR:  taken = (count_result != 32'h0) & ~rb_zero;
      `BIC_OP_IHB:  taken = ($signed(index_sum) > $signed(comparand));
      default:      taken = 1'b0;
    endcase
  end
endmodule

// [bic_core.v]
`timescale 1ns/100ps
`include "bic_consts.vh"
module bic_core #(
  parameter AW = 8
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire [2:0]    s_axi_awprot,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output wire [1:0]    s_axi_bresp,
  output wire          s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire [2:0]    s_axi_arprot,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output wire [31:0]   s_axi_rdata,
  output wire [1:0]    s_axi_rresp,
  output wire          s_axi_rvalid,
  input  wire          s_axi_rready
);
  localparam S_IDLE = 2'd0;
  localparam S_DEC  = 2'd1;
  localparam S_EXE  = 2'd2;
  localparam S_END  = 2'd3;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // instruction length in halfwords from the top two opcode bits
  function [1:0] fmt_len;
    input [7:0] op;
    begin
      case (op[7:6])
        2'b00:   fmt_len = 2'd1;
        2'b11:   fmt_len = 2'd3;
        default: fmt_len = 2'd2;
      endcase
    end
  endfunction

  function [31:0] wmask;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      i;
    begin
      wmask = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          wmask[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [31:0]   greg_q [0:15];
  reg [1:0]    state_q;
  reg          awready_q;
  reg          wready_q;
  reg          bvalid_q;
  reg [1:0]    bresp_q;
  reg          arready_q;
  reg          rvalid_q;
  reg [1:0]    rresp_q;
  reg [31:0]   rdata_q;
  reg          aw_hold_q;
  reg          w_hold_q;
  reg [7:0]    aw_addr_q;
  reg [31:0]   w_data_q;
  reg [3:0]    w_strb_q;
  reg          rstab_q;
  reg          lasthw_q;
  reg [3:0]    key_q;
  reg [1:0]    ccode_q;
  reg [31:0]   instr_q;
  reg [31:0]   icnt_q;
  reg [31:0]   link_q;
  reg [31:0]   d_q;
  reg [4:0]    skey_q;
  reg [31:0]   mtop_q;
  reg [31:0]   subj_q;
  reg [31:0]   xsub_q;
  reg [31:0]   nextr_q;
  reg [31:0]   sbus_q;
  reg [31:0]   next_q;
  reg          busy_q;
  reg          taken_q;
  reg          bend_q;
  reg [1:0]    fmt_q;
  reg [3:0]    pic_q;
  reg [31:0]   a_q;
  reg [31:0]   b_q;
  reg [31:0]   c_q;
  reg [31:0]   rd_val;
  reg          rd_ok;
  reg          wr_ok;
  reg [3:0]    pic_d;
  integer      k;

  wire [7:0]   op     = instr_q[31:24];
  wire [3:0]   f_ra   = instr_q[23:20];
  wire [3:0]   f_rb   = instr_q[19:16];
  wire [3:0]   f_base = instr_q[15:12];
  wire [11:0]  f_disp = instr_q[11:0];
  wire         is_rr  = (op[7:6] == 2'b00);
  wire         is_ex  = (op == `BIC_OP_EX);
  wire [3:0]   cmp_rn = f_rb | 4'h1;
  wire [31:0]  agen_addr;
  wire         taken;
  wire [31:0]  cnt_res = a_q - 32'h1;
  wire [31:0]  idx_sum = a_q + b_q;
  wire         ar_go  = s_axi_arvalid & arready_q;
  wire [7:0]   ar_a   = s_axi_araddr[7:0];

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // ----------------------------------------
  // address and condition units
  // ----------------------------------------
  bic_addr_gen u_agen (
    .index_register_field (f_rb),
    .base_register_field  (f_base),
    .displacement_field   (f_disp),
    .use_index            (op != `BIC_OP_IHB),
    .index_val            (greg_q[f_rb]),
    .base_val             (greg_q[f_base]),
    .addr                 (agen_addr)
  );

  bic_cond_eval u_cond (
    .opcode               (op),
    .condition_mask_field (f_ra),
    .condition_code       (ccode_q),
    .rb_zero              (f_rb == 4'h0),
    .count_result         (cnt_res),
    .index_sum            (idx_sum),
    .comparand            (c_q),
    .taken                (taken)
  );

  // ----------------------------------------
  // interruption priority
  // ----------------------------------------
  always @* begin
    if (is_ex && d_q[0]) begin
      pic_d = `BIC_PIC_SPEC;
    end else if (is_ex && (d_q >= mtop_q)) begin
      pic_d = `BIC_PIC_ADDR;
    end else if ((taken || is_ex) && skey_q[`BIC_SK_FP]
                 && key_q != `BIC_MASTER_KEY && key_q != skey_q[3:0]) begin
      pic_d = `BIC_PIC_PROT;
    end else if (is_ex && subj_q[31:24] == `BIC_OP_EX) begin
      pic_d = `BIC_PIC_EXEC;
    end else begin
      pic_d = `BIC_PIC_NONE;
    end
  end

  // ----------------------------------------
  // register read decode
  // ----------------------------------------
  always @* begin
    rd_ok  = 1'b1;
    rd_val = 32'h0;
    if (ar_a[7:6] == `BIC_GREG_SEL) begin
      rd_val = greg_q[ar_a[5:2]];
    end else begin
      case ({ar_a[7:2], 2'b00})
        `BIC_CTRL:  rd_val = {22'h0, ccode_q, key_q, 1'b0, lasthw_q, rstab_q, 1'b0};
        `BIC_INSTR: rd_val = instr_q;
        `BIC_ICNT:  rd_val = icnt_q;
        `BIC_LINK:  rd_val = link_q;
        `BIC_STAT:  rd_val = {20'h0, pic_q, 2'b00, fmt_q, 1'b0, bend_q, taken_q, busy_q};
        `BIC_DADDR: rd_val = d_q;
        `BIC_SKEY:  rd_val = {27'h0, skey_q};
        `BIC_MTOP:  rd_val = mtop_q;
        `BIC_SUBJ:  rd_val = subj_q;
        `BIC_XSUB:  rd_val = xsub_q;
        `BIC_NEXTR: rd_val = nextr_q;
        `BIC_SBUS:  rd_val = sbus_q;
        `BIC_NEXT:  rd_val = next_q;
        default:    rd_ok = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  always @* begin
    wr_ok = (aw_addr_q[7:6] == `BIC_GREG_SEL);
    case ({aw_addr_q[7:2], 2'b00})
      `BIC_CTRL, `BIC_INSTR, `BIC_ICNT, `BIC_LINK, `BIC_SKEY, `BIC_MTOP,
      `BIC_SUBJ, `BIC_NEXTR, `BIC_SBUS, `BIC_STAT, `BIC_DADDR, `BIC_XSUB,
      `BIC_NEXT: wr_ok = 1'b1;
      default:   wr_ok = (aw_addr_q[7:6] == `BIC_GREG_SEL);
    endcase
  end

  // ----------------------------------------
  // bus slave, software registers and sequencer
  // ----------------------------------------
  // one process owns every register so the sequencer can override a
  // coincident software write to the same general register
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (k = 0; k < 16; k = k + 1) begin
        greg_q[k] <= 32'h0;
      end
      state_q   <= S_IDLE;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `BIC_RESP_OK;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `BIC_RESP_OK;
      rdata_q   <= 32'h0;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= 8'h0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      rstab_q   <= 1'b0;
      lasthw_q  <= 1'b0;
      key_q     <= 4'h0;
      ccode_q   <= 2'h0;
      instr_q   <= 32'h0;
      icnt_q    <= 32'h0;
      link_q    <= 32'h0;
      d_q       <= 32'h0;
      skey_q    <= 5'h0;
      mtop_q    <= `BIC_MTOP_RST;
      subj_q    <= 32'h0;
      xsub_q    <= 32'h0;
      nextr_q   <= 32'h0;
      sbus_q    <= 32'h0;
      next_q    <= 32'h0;
      busy_q    <= 1'b0;
      taken_q   <= 1'b0;
      bend_q    <= 1'b0;
      fmt_q     <= 2'h0;
      pic_q     <= 4'h0;
      a_q       <= 32'h0;
      b_q       <= 32'h0;
      c_q       <= 32'h0;
    end else begin
      // write channels are taken independently, answered once both held
      if (s_axi_awvalid && awready_q) begin
        aw_addr_q <= s_axi_awaddr[7:0];
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (aw_hold_q && w_hold_q && !bvalid_q) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? `BIC_RESP_OK : `BIC_RESP_ERR;
        if (aw_addr_q[7:6] == `BIC_GREG_SEL) begin
          greg_q[aw_addr_q[5:2]] <= wmask(greg_q[aw_addr_q[5:2]], w_data_q, w_strb_q);
        end else begin
          case ({aw_addr_q[7:2], 2'b00})
            `BIC_CTRL: begin
              if (w_strb_q[0]) begin
                rstab_q  <= w_data_q[`BIC_CTRL_RSTAB];
                lasthw_q <= w_data_q[`BIC_CTRL_LASTHW];
                key_q    <= w_data_q[`BIC_CTRL_KEY_LO +: 4];
              end
              if (w_strb_q[1]) begin
                ccode_q <= w_data_q[`BIC_CTRL_CODE_LO +: 2];
              end
              // start is ignored while an instruction is under way
              if (w_strb_q[0] && w_data_q[`BIC_CTRL_START] && !busy_q) begin
                busy_q  <= 1'b1;
                pic_q   <= `BIC_PIC_NONE;
                state_q <= S_DEC;
              end
            end
            `BIC_INSTR: instr_q <= wmask(instr_q, w_data_q, w_strb_q);
            `BIC_ICNT:  icnt_q  <= wmask(icnt_q, w_data_q, w_strb_q);
            `BIC_LINK:  link_q  <= wmask(link_q, w_data_q, w_strb_q);
            `BIC_SKEY: begin
              if (w_strb_q[0]) begin
                skey_q <= w_data_q[4:0];
              end
            end
            `BIC_MTOP:  mtop_q  <= wmask(mtop_q, w_data_q, w_strb_q);
            `BIC_SUBJ:  subj_q  <= wmask(subj_q, w_data_q, w_strb_q);
            `BIC_NEXTR: nextr_q <= wmask(nextr_q, w_data_q, w_strb_q);
            `BIC_SBUS:  sbus_q  <= wmask(sbus_q, w_data_q, w_strb_q);
            default: begin
            end
          endcase
        end
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
      if (ar_go) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_val;
        rresp_q   <= rd_ok ? `BIC_RESP_OK : `BIC_RESP_ERR;
      end
      if (rvalid_q && s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
      case (state_q)
        S_IDLE: begin
        end
        S_DEC: begin
          // assume success and point the fetch address at the target
          a_q     <= greg_q[f_ra];
          b_q     <= greg_q[f_rb];
          c_q     <= greg_q[cmp_rn];
          d_q     <= is_rr ? greg_q[f_rb] : agen_addr;
          state_q <= S_EXE;
        end
        S_EXE: begin
          pic_q   <= pic_d;
          taken_q <= taken & (pic_d == `BIC_PIC_NONE);
          if (!taken || pic_d != `BIC_PIC_NONE) begin
            d_q <= icnt_q;
          end
          if (pic_d == `BIC_PIC_NONE) begin
            case (op)
              `BIC_OP_LBX, `BIC_OP_LBR: greg_q[f_ra] <= link_q;
              `BIC_OP_CBX, `BIC_OP_CBR: greg_q[f_ra] <= cnt_res;
              `BIC_OP_IHB:              greg_q[f_ra] <= idx_sum;
              `BIC_OP_EX: begin
                // zero first field leaves the subject unmodified
                xsub_q <= {subj_q[31:24],
                           subj_q[23:16] | ((f_ra != 4'h0) ? a_q[7:0] : 8'h00),
                           subj_q[15:0]};
              end
              default: begin
              end
            endcase
          end
          state_q <= S_END;
        end
        S_END: begin
          // bus decode saves the settling time of the next-instruction register
          if (!rstab_q && !lasthw_q) begin
            bend_q <= 1'b1;
            next_q <= d_q;
            fmt_q  <= fmt_len(sbus_q[31:24]);
          end else begin
            bend_q <= 1'b0;
            next_q <= icnt_q;
            fmt_q  <= fmt_len(nextr_q[31:24]);
          end
          busy_q  <= 1'b0;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// [bic_stor_model.sv]
`timescale 1ns/100ps
module bic_stor_model (
  input  wire [31:0] tgt,
  input  wire [31:0] mtop,
  input  wire [4:0]  skey,
  input  wire [3:0]  key,
  input  wire        is_ex,
  input  wire [7:0]  subj_op,
  output logic [3:0] pic
);
  // ------------------------------------------
  // storage side: protection and installed size
  // ------------------------------------------
  wire fp = skey[4];
  wire ok = !fp || key == skey[3:0] || key == 4'h0;
  // one code only: the first failing check wins
  always @* begin
    if (is_ex && tgt[0])
      pic = 4'h6;
    else if (is_ex && tgt >= mtop)
      pic = 4'h5;
    else if (!ok)
      pic = 4'h4;
    else if (is_ex && subj_op == 8'h44)
      pic = 4'h3;
    else
      pic = 4'h0;
  end
endmodule

// [bic_core_checker.sv]
`timescale 1ns/100ps
module bic_core_checker #(
  parameter AW = 8
) (
  input wire          aclk,
  input wire          aresetn,
  input wire [AW-1:0] s_axi_awaddr,
  input wire          s_axi_awvalid,
  input wire          s_axi_awready,
  input wire [31:0]   s_axi_wdata,
  input wire [3:0]    s_axi_wstrb,
  input wire          s_axi_wvalid,
  input wire          s_axi_wready,
  input wire [1:0]    s_axi_bresp,
  input wire          s_axi_bvalid,
  input wire          s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire          s_axi_arvalid,
  input wire          s_axi_arready,
  input wire [31:0]   s_axi_rdata,
  input wire [1:0]    s_axi_rresp,
  input wire          s_axi_rvalid,
  input wire          s_axi_rready
);
  // ------------------------------------------
  // shadows: last read address, last written condition code
  // ------------------------------------------
  logic [AW-1:0] ar_q;
  logic [1:0]    ccode_q;
  wire           wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // only joint address and data writes tracked, as the bench issues them
  always @(posedge aclk) begin
    if (!aresetn) begin
      ar_q <= '0;
      ccode_q <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready)
        ar_q <= s_axi_araddr;
      if (wr_take && s_axi_awaddr[AW-1:2] == '0 && s_axi_wstrb[1])
        ccode_q <= s_axi_wdata[9:8];
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    wr_take;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_ctrl;
    s_axi_rvalid && ar_q[AW-1:2] == '0;
  endsequence
  a_write_answer: assert property (s_wr |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_rd |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  a_hole_error: assert property (s_rd ##0 (s_axi_araddr >= 8'h34 && s_axi_araddr < 8'h40)
    |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  a_map_okay: assert property (s_rd ##0 (s_axi_araddr < 8'h34) |=> s_axi_rresp == 2'h0)
    else $error("mapped read refused");
  a_code_kept: assert property (s_ctrl |-> s_axi_rdata[9:8] == ccode_q)
    else $error("condition code changed by hardware");
  a_start_clear: assert property (s_ctrl |-> !s_axi_rdata[0])
    else $error("start bit reads back set");
endmodule

bind bic_core bic_core_checker #(.AW(AW)) u_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// [branch_instruction_control_tb_top.sv]
`timescale 1ns/100ps
module branch_instruction_control_tb_top;
  localparam logic [31:0] all1 = 32'hffffffff;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stall, m_ex, tk;
  logic [7:0]  awaddr, araddr, m_sop;
  logic [31:0] wdata, d, stat, m_tgt;
  logic [4:0]  m_sk;
  logic [3:0]  m_key;
  logic [1:0]  rsp;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [3:0]  m_pic;
  int          err_total, n_checks, i, j, k;

  bic_core #(.AW(8)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  bic_stor_model u_stor (
    .tgt(m_tgt), .mtop(32'h2000), .skey(m_sk), .key(m_key), .is_ex(m_ex),
    .subj_op(m_sop), .pic(m_pic)
  );

  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end

  // ------------------------------------------
  // bus tasks
  // ------------------------------------------
  function automatic logic [7:0] ga(input logic [3:0] n);
    ga = {2'h1, n, 2'h0};
  endfunction
  function automatic logic [31:0] cw(input logic [1:0] cd, input logic [3:0] ky,
                                     input logic rs, input logic lh);
    cw = {22'h0, cd, ky, 1'h0, lh, rs, 1'h0};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= !stall;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready === 1'h1)
        awvalid <= 1'h0;
      if (wvalid && wready === 1'h1)
        wvalid <= 1'h0;
      if (bvalid === 1'h1 && bready) begin
        bready <= 1'h0;
        rsp = bresp;
        done = 1'h1;
      end else if (bvalid === 1'h1)
        bready <= 1'h1;
    end
  endtask
  task rd(input logic [7:0] a);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= !stall;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready === 1'h1)
        arvalid <= 1'h0;
      if (rvalid === 1'h1 && rready) begin
        rready <= 1'h0;
        d = rdata;
        rsp = rresp;
        done = 1'h1;
      end else if (rvalid === 1'h1)
        rready <= 1'h1;
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(d & m, e);
  endtask
  task run(input logic [31:0] ins, input logic [31:0] ctl);
    wr(8'h04, ins);
    wr(8'h00, ctl | 32'h1);
    stat = 32'h1;
    while (stat[0] !== 1'h0) begin
      rd(8'h10);
      stat = d;
    end
  endtask
  task ex_case(input logic [11:0] dd, input logic [7:0] so, input logic [4:0] sk,
               input logic [3:0] ky);
    m_tgt = 32'h1800 + {20'h0, dd};
    m_sk  = sk;
    m_key = ky;
    m_sop = so;
    wr(8'h18, {27'h0, sk});
    wr(8'h20, {so, 24'h0});
    run({8'h44, 8'h10, 4'h2, dd}, cw(2'h0, ky, 1'h1, 1'h1));
    chk(stat & 32'hf02, {20'h0, m_pic, 8'h0});
    if (m_pic === 4'h0)
      rc(8'h24, all1, {so, 8'h34, 16'h0});
  endtask
  task conclude;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------
  // watchdog: the sequence needs under 10000 cycles
  // ------------------------------------------
  initial begin
    #(100 * 40000);
    err_total++;
    conclude();
  end

  initial begin
    aresetn = 1'h0;
    awvalid = 1'h0;
    wvalid  = 1'h0;
    bready  = 1'h0;
    arvalid = 1'h0;
    rready  = 1'h0;
    awaddr  = 8'h0;
    araddr  = 8'h0;
    wdata   = 32'h0;
    stall   = 1'h0;
    m_ex    = 1'h1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rc(8'h1c, all1, 32'h00010000);
    rc(8'h10, all1, 32'h0);
    rd(8'h34);
    chk({30'h0, rsp}, 32'h2);
    wr(8'h38, 32'h1);
    chk({30'h0, rsp}, 32'h2);
    wr(8'h0c, 32'h12345678);
    wr(8'h08, 32'h200);
    wr(8'h28, 32'h05000000);
    wr(8'h2c, 32'h45000000);
    wr(ga(4'h1), 32'h100);
    wr(ga(4'h2), 32'h20);
    // slow master: ready only after valid is seen
    stall = 1'h1;
    run(32'h4531200c, cw(2'h2, 4'h0, 1'h1, 1'h0));
    stall = 1'h0;
    rc(ga(4'h3), all1, 32'h12345678);
    rc(8'h14, all1, 32'h12c);
    chk(stat & 32'hf3e, 32'h12);
    rc(8'h30, all1, 32'h200);
    rc(8'h00, 32'h301, 32'h200);
    run(32'h4531200c, cw(2'h2, 4'h0, 1'h0, 1'h0));
    chk(stat & 32'hf3e, 32'h26);
    rc(8'h30, all1, 32'h12c);
    wr(8'h0c, 32'h0badf00d);
    run(32'h05300000, cw(2'h1, 4'h0, 1'h1, 1'h1));
    rc(ga(4'h3), all1, 32'h0badf00d);
    chk(stat & 32'h2, 32'h0);
    rc(8'h14, all1, 32'h200);
    run(32'h05310000, cw(2'h1, 4'h0, 1'h1, 1'h1));
    rc(8'h14, all1, 32'h100);
    for (k = 0; k < 2; k++)
      for (i = 0; i < 4; i++)
        for (j = 0; j < 16; j++) begin
          run({k ? 8'h07 : 8'h47, j[3:0], 8'h21, 12'h040}, cw(i[1:0], 4'h0, 1'h1, 1'h1));
          tk = j[3-i];
          chk(stat & 32'h2, {30'h0, tk, 1'h0});
          rc(8'h14, all1, tk ? (k ? 32'h20 : 32'h160) : 32'h200);
        end
    run(32'h07f01040, cw(2'h0, 4'h0, 1'h1, 1'h1));
    chk(stat & 32'h2, 32'h0);
    wr(ga(4'h5), 32'h1);
    run(32'h46501008, cw(2'h0, 4'h0, 1'h1, 1'h1));
    rc(ga(4'h5), all1, 32'h0);
    chk(stat & 32'h2, 32'h0);
    run(32'h46501008, cw(2'h0, 4'h0, 1'h1, 1'h1));
    rc(ga(4'h5), all1, 32'hffffffff);
    rc(8'h14, all1, 32'h108);
    run(32'h06500000, cw(2'h0, 4'h0, 1'h1, 1'h1));
    rc(ga(4'h5), all1, 32'hfffffffe);
    chk(stat & 32'h2, 32'h0);
    wr(ga(4'h1), 32'h5);
    wr(ga(4'h2), 32'hfffffffd);
    wr(ga(4'h3), 32'h2);
    run(32'h86123010, cw(2'h0, 4'h0, 1'h1, 1'h1));
    rc(ga(4'h1), all1, 32'h2);
    chk(stat & 32'h2, 32'h0);
    wr(ga(4'h1), 32'h2);
    wr(ga(4'h3), 32'hffffffff);
    run(32'h86133010, cw(2'h0, 4'h0, 1'h1, 1'h1));
    rc(ga(4'h1), all1, 32'h1);
    chk(stat & 32'h2, 32'h2);
    rc(8'h14, all1, 32'hf);
    wr(ga(4'h1), 32'h34);
    wr(ga(4'h2), 32'h1800);
    wr(8'h1c, 32'h2000);
    ex_case(12'h100, 8'h1a, 5'h00, 4'h0);
    ex_case(12'h101, 8'h1a, 5'h00, 4'h0);
    ex_case(12'h800, 8'h1a, 5'h00, 4'h0);
    ex_case(12'h100, 8'h44, 5'h00, 4'h0);
    ex_case(12'h100, 8'h1a, 5'h15, 4'h3);
    ex_case(12'h100, 8'h1a, 5'h15, 4'h5);
    ex_case(12'h100, 8'h1a, 5'h15, 4'h0);
    ex_case(12'h100, 8'h1a, 5'h05, 4'h3);
    m_ex = 1'h0;
    wr(8'h18, 32'h15);
    wr(ga(4'h3), 32'h0);
    run(32'h4531200c, cw(2'h0, 4'h3, 1'h1, 1'h1));
    chk(stat & 32'hf02, 32'h400);
    rc(ga(4'h3), all1, 32'h0);
    conclude();
  end
endmodule
